// [design/addr_decode_gate.sv]
// base address range check for one logical device
`default_nettype none
module addr_decode_gate (
  // host cycle
  input wire logic [15:0] host_addr,
  input wire logic [15:0] base_addr,
  input wire logic [15:0] range_len,
  // results
  output logic in_range,
  output logic decode_enable
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // power state is deliberately not an input: a powered-down device still claims its range
  assign decode_enable = (base_addr >= cfg_regs_pkg::BASE_ADDR_MIN); // R7
  assign in_range = decode_enable && (host_addr >= base_addr) &&
                    ({1'b0, host_addr} < ({1'b0, base_addr} + {1'b0, range_len})); // R8
endmodule
`default_nettype wire

// [design/serial_floppy_config_regs.sv]
// serial port power and floppy miscellaneous configuration registers
//
// Behaviour
// R1 - power-on reset loads serial power 0x08
// R2 - hard reset clears secondary port power bit
// R3 - serial power bits 0-2,4-6 read zero
// R4 - bit 3 powers primary serial port
// R5 - bit 7 powers secondary port and infrared
// R6 - power down leaves address decode alone
// R7 - decode stops only when base below 100h
// R8 - powered-down device still does range checking
// R9 - floppy misc reached at index 03h, config
// R10 - next register reached at index 04h, config
// R11 - power-on reset loads floppy misc 0x70
// R12 - bit 1 selects enhanced floppy mode 2
// R13 - bit 4 forces density output high
// R14 - bits 6:5 pick interface personality
// R15 - cleared lock bit blocks all config access
// R16 - writes to read-only bits are ignored
`default_nettype none
module serial_floppy_config_regs (
  // clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hard_reset,
  // configuration access (index already loaded)
  input wire logic config_state,
  input wire cfg_regs_pkg::cfg_access_t acc,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic next_reg_sel,
  // lock state
  output logic configuration_lock_bit,
  // device address decode
  input wire logic [15:0] host_addr,
  input wire logic [15:0] primary_base,
  input wire logic [15:0] secondary_base,
  output logic primary_addr_hit,
  output logic secondary_addr_hit,
  // power and floppy controls
  output cfg_regs_pkg::serial_power_t serial_power,
  output cfg_regs_pkg::floppy_ctrl_t floppy_ctrl,
  input wire logic density_programmed,
  output logic drive_density_select_out
);
  logic [1:0] hard_sync_r;
  logic hard_pulse_r;
  logic lock_r;
  logic [7:0] serial_port_power_r;
  logic [7:0] floppy_misc_config_r;
  logic [7:0] rdata_r;
  logic rdata_valid_r;
  logic access_ok;
  logic wr_power;
  logic wr_floppy;
  logic wr_lock;
  logic prim_dec_en;
  logic sec_dec_en;

  function automatic logic idx_hit(input logic [7:0] idx, input logic [7:0] want);
    idx_hit = (idx == want);
  endfunction

  // ---------------------------------------------------------------
  // hard reset synchroniser
  // ---------------------------------------------------------------
  // hard reset is a pin from outside; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hard_sync_r <= 2'h0;
    end else begin
      hard_sync_r <= {hard_sync_r[0], hard_reset};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hard_pulse_r <= 1'b0;
    end else begin
      hard_pulse_r <= hard_sync_r[1];
    end
  end

  // ---------------------------------------------------------------
  // access gating
  // ---------------------------------------------------------------
  assign access_ok = config_state && lock_r; // R15
  assign wr_power = access_ok && acc.wr && idx_hit(acc.index, cfg_regs_pkg::IDX_SERIAL_PORT_POWER);
  assign wr_floppy = access_ok && acc.wr && idx_hit(acc.index, cfg_regs_pkg::IDX_FLOPPY_MISC_CONFIG); // R9
  assign wr_lock = access_ok && acc.wr && idx_hit(acc.index, cfg_regs_pkg::IDX_PORT_LOCK);
  // the neighbouring register lives elsewhere; we only flag its selection
  assign next_reg_sel = access_ok && (acc.wr || acc.rd) &&
                        idx_hit(acc.index, cfg_regs_pkg::IDX_PARALLEL_SERIAL_MISC); // R10

  // ---------------------------------------------------------------
  // lock bit
  // ---------------------------------------------------------------
  // once cleared, software cannot set it again; only resets reopen access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_r <= 1'b1;
    end else if (hard_pulse_r) begin
      lock_r <= 1'b1; // R15
    end else if (wr_lock && !acc.wdata[cfg_regs_pkg::LOCK_BIT]) begin
      lock_r <= 1'b0; // R15
    end
  end

  // ---------------------------------------------------------------
  // serial port power register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_port_power_r <= cfg_regs_pkg::SERIAL_POWER_POR; // R1
    end else if (hard_pulse_r) begin
      serial_port_power_r[cfg_regs_pkg::SEC_PWR_BIT] <= 1'b0; // R2
    end else if (wr_power) begin
      serial_port_power_r <= acc.wdata & cfg_regs_pkg::SERIAL_POWER_MASK; // R3 R16
    end
  end

  // ---------------------------------------------------------------
  // floppy miscellaneous register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      floppy_misc_config_r <= cfg_regs_pkg::FLOPPY_MISC_POR; // R11
    end else if (wr_floppy) begin
      floppy_misc_config_r <= acc.wdata & cfg_regs_pkg::FLOPPY_MISC_MASK; // R16
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
      rdata_valid_r <= 1'b0;
    end else begin
      rdata_valid_r <= access_ok && acc.rd; // R15
      if (access_ok && acc.rd) begin
        case (acc.index)
          cfg_regs_pkg::IDX_SERIAL_PORT_POWER: rdata_r <= serial_port_power_r & cfg_regs_pkg::SERIAL_POWER_MASK; // R3
          cfg_regs_pkg::IDX_FLOPPY_MISC_CONFIG: rdata_r <= floppy_misc_config_r & cfg_regs_pkg::FLOPPY_MISC_MASK;
          cfg_regs_pkg::IDX_PORT_LOCK: rdata_r <= {lock_r, 7'h00};
          default: rdata_r <= 8'h00;
        endcase
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  assign rdata = rdata_r;
  assign rdata_valid = rdata_valid_r;
  assign configuration_lock_bit = lock_r;

  // ---------------------------------------------------------------
  // power controls
  // ---------------------------------------------------------------
  assign serial_power.primary_enable = serial_port_power_r[cfg_regs_pkg::PRI_PWR_BIT]; // R4
  assign serial_power.secondary_enable = serial_port_power_r[cfg_regs_pkg::SEC_PWR_BIT]; // R5
  assign serial_power.infrared_enable = serial_port_power_r[cfg_regs_pkg::SEC_PWR_BIT]; // R5

  // ---------------------------------------------------------------
  // floppy controls
  // ---------------------------------------------------------------
  assign floppy_ctrl.enhanced_mode2 = floppy_misc_config_r[cfg_regs_pkg::ENH_MODE_BIT]; // R12
  assign floppy_ctrl.density_force_high = floppy_misc_config_r[cfg_regs_pkg::DENS_FORCE_BIT]; // R13
  assign floppy_ctrl.personality = cfg_regs_pkg::personality_t'(
    {floppy_misc_config_r[cfg_regs_pkg::PERS_HI_BIT], floppy_misc_config_r[cfg_regs_pkg::PERS_LO_BIT]}); // R14
  // density_programmed is same-clock logic from the floppy core
  assign drive_density_select_out = floppy_misc_config_r[cfg_regs_pkg::DENS_FORCE_BIT] ?
                                    1'b1 : density_programmed; // R13

  // ---------------------------------------------------------------
  // address decode per serial port
  // ---------------------------------------------------------------
  // decode takes no power input on purpose
  addr_decode_gate u_prim_dec (
    .host_addr(host_addr),
    .base_addr(primary_base),
    .range_len(16'h0008),
    .in_range(primary_addr_hit), // R6
    .decode_enable(prim_dec_en)
  );
  addr_decode_gate u_sec_dec (
    .host_addr(host_addr),
    .base_addr(secondary_base),
    .range_len(16'h0008),
    .in_range(secondary_addr_hit), // R6
    .decode_enable(sec_dec_en)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_hard_edge;
    hard_pulse_r;
  endsequence
  sequence s_lock_clear;
    wr_lock && !acc.wdata[cfg_regs_pkg::LOCK_BIT] && !hard_pulse_r;
  endsequence

  a_power_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // R3
    (serial_port_power_r & ~cfg_regs_pkg::SERIAL_POWER_MASK) == 8'h00)
    else $error("reserved serial power bits not zero");
  a_hard_clears_sec: assert property (@(posedge clk) disable iff (!rst_n) // R2
    s_hard_edge |=> !serial_power.secondary_enable)
    else $error("hard reset did not clear secondary power");
  a_primary_follows_bit: assert property (@(posedge clk) disable iff (!rst_n) // R4
    wr_power && !hard_pulse_r |=> serial_power.primary_enable == $past(acc.wdata[3]))
    else $error("primary power not following write");
  a_sec_ir_together: assert property (@(posedge clk) disable iff (!rst_n) // R5
    serial_power.secondary_enable == serial_power.infrared_enable)
    else $error("infrared power differs from secondary");
  a_floppy_write_masked: assert property (@(posedge clk) disable iff (!rst_n) // R16
    wr_floppy |=> floppy_misc_config_r == ($past(acc.wdata) & cfg_regs_pkg::FLOPPY_MISC_MASK))
    else $error("floppy misc write wrong");
  a_density_forced: assert property (@(posedge clk) disable iff (!rst_n) // R13
    floppy_ctrl.density_force_high |-> drive_density_select_out)
    else $error("density output not forced high");
  a_lock_blocks_write: assert property (@(posedge clk) disable iff (!rst_n) // R15
    !lock_r && !hard_pulse_r |=> $stable(serial_port_power_r) && $stable(floppy_misc_config_r))
    else $error("write passed while locked");
  a_lock_sticky: assert property (@(posedge clk) disable iff (!rst_n) // R15
    !lock_r && !hard_pulse_r |=> !lock_r)
    else $error("lock reopened without reset");
  a_decode_low_base: assert property (@(posedge clk) disable iff (!rst_n) // R7
    primary_base < cfg_regs_pkg::BASE_ADDR_MIN |-> !primary_addr_hit && !prim_dec_en)
    else $error("decode active below 100h");
  a_decode_ignores_power: assert property (@(posedge clk) disable iff (!rst_n) // R8
    sec_dec_en && host_addr == secondary_base |-> secondary_addr_hit)
    else $error("powered-down device dropped its range");
  a_read_index03: assert property (@(posedge clk) disable iff (!rst_n) // R9
    access_ok && acc.rd && acc.index == cfg_regs_pkg::IDX_FLOPPY_MISC_CONFIG
    |=> rdata_valid && rdata == $past(floppy_misc_config_r))
    else $error("floppy misc read wrong");
  a_personality_map: assert property (@(posedge clk) disable iff (!rst_n) // R14
    floppy_ctrl.personality == cfg_regs_pkg::personality_t'(floppy_misc_config_r[6:5]))
    else $error("personality mismatch");
  a_enh_mode: assert property (@(posedge clk) disable iff (!rst_n) // R12
    floppy_ctrl.enhanced_mode2 == floppy_misc_config_r[1])
    else $error("enhanced mode mismatch");
  a_next_sel: assert property (@(posedge clk) disable iff (!rst_n) // R10
    next_reg_sel |-> config_state && lock_r)
    else $error("next register selected outside config");
  a_por_serial: assert property (@(posedge clk) disable iff (!rst_n) // R1
    $rose(rst_n) |-> serial_port_power_r == cfg_regs_pkg::SERIAL_POWER_POR)
    else $error("serial power not at power-on value");
  a_por_floppy: assert property (@(posedge clk) disable iff (!rst_n) // R11
    $rose(rst_n) |-> floppy_misc_config_r == cfg_regs_pkg::FLOPPY_MISC_POR)
    else $error("floppy misc not at power-on value");
  a_read_power_zero: assert property (@(posedge clk) disable iff (!rst_n) // R3
    access_ok && acc.rd && acc.index == cfg_regs_pkg::IDX_SERIAL_PORT_POWER
    |=> rdata_valid && (rdata & ~cfg_regs_pkg::SERIAL_POWER_MASK) == 8'h00)
    else $error("reserved serial power bits read nonzero");
  a_power_write_masked: assert property (@(posedge clk) disable iff (!rst_n) // R16
    wr_power && !hard_pulse_r |=> serial_port_power_r == ($past(acc.wdata) & cfg_regs_pkg::SERIAL_POWER_MASK))
    else $error("serial power write wrong");
  a_sec_follows_bit: assert property (@(posedge clk) disable iff (!rst_n) // R5
    wr_power && !hard_pulse_r |=> serial_power.secondary_enable == $past(acc.wdata[cfg_regs_pkg::SEC_PWR_BIT]))
    else $error("secondary power not following write");
  a_power_hold: assert property (@(posedge clk) disable iff (!rst_n) // R4
    !wr_power && !hard_pulse_r |=> $stable(serial_port_power_r))
    else $error("serial power changed without write");
  a_hard_keeps_primary: assert property (@(posedge clk) disable iff (!rst_n) // R2
    s_hard_edge |=> $stable(serial_power.primary_enable))
    else $error("hard reset touched primary power");
  a_hard_keeps_floppy: assert property (@(posedge clk) disable iff (!rst_n) // R2
    hard_pulse_r && !wr_floppy |=> $stable(floppy_misc_config_r))
    else $error("hard reset touched floppy misc");
  a_hard_opens_lock: assert property (@(posedge clk) disable iff (!rst_n) // R15
    s_hard_edge |=> lock_r)
    else $error("hard reset did not reopen access");
  a_lock_clear: assert property (@(posedge clk) disable iff (!rst_n) // R15
    s_lock_clear |=> !lock_r)
    else $error("lock write did not close access");
  a_lock_readback: assert property (@(posedge clk) disable iff (!rst_n) // R15
    access_ok && acc.rd && acc.index == cfg_regs_pkg::IDX_PORT_LOCK |=> rdata == 8'h80)
    else $error("lock readback wrong");
  a_refused_read: assert property (@(posedge clk) disable iff (!rst_n) // R15
    !access_ok |=> !rdata_valid)
    else $error("read answered while refused");
  a_outside_config: assert property (@(posedge clk) disable iff (!rst_n) // R9
    !config_state && acc.rd |=> !rdata_valid)
    else $error("read answered outside config state");
  a_outside_no_write: assert property (@(posedge clk) disable iff (!rst_n) // R9
    !config_state |=> $stable(floppy_misc_config_r))
    else $error("floppy misc written outside config state");
  a_next_sel_hit: assert property (@(posedge clk) disable iff (!rst_n) // R10
    config_state && lock_r && acc.rd && acc.index == cfg_regs_pkg::IDX_PARALLEL_SERIAL_MISC |-> next_reg_sel)
    else $error("next register not selected");
  a_density_follows: assert property (@(posedge clk) disable iff (!rst_n) // R13
    !floppy_ctrl.density_force_high |-> drive_density_select_out == density_programmed)
    else $error("density output not following programmed value");
  a_decode_sec_low: assert property (@(posedge clk) disable iff (!rst_n) // R7
    secondary_base < cfg_regs_pkg::BASE_ADDR_MIN |-> !secondary_addr_hit && !sec_dec_en)
    else $error("secondary decode active below 100h");
  a_decode_enable_high: assert property (@(posedge clk) disable iff (!rst_n) // R7
    primary_base >= cfg_regs_pkg::BASE_ADDR_MIN |-> prim_dec_en)
    else $error("decode off for valid base");
endmodule
`default_nettype wire

// [pkg/cfg_regs_pkg.sv]
// package: offsets, field positions, reset values and types for the serial/floppy config registers
`default_nettype none
package cfg_regs_pkg;
  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_PORT_LOCK = 8'h01;
  localparam logic [7:0] IDX_SERIAL_PORT_POWER = 8'h02;
  localparam logic [7:0] IDX_FLOPPY_MISC_CONFIG = 8'h03;
  localparam logic [7:0] IDX_PARALLEL_SERIAL_MISC = 8'h04;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LOCK_BIT = 7;
  localparam int PRI_PWR_BIT = 3;
  localparam int SEC_PWR_BIT = 7;
  localparam int ENH_MODE_BIT = 1;
  localparam int DENS_FORCE_BIT = 4;
  localparam int PERS_LO_BIT = 5;
  localparam int PERS_HI_BIT = 6;
  // ---------------------------------------------------------------
  // reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] SERIAL_POWER_POR = 8'h08;
  localparam logic [7:0] SERIAL_POWER_MASK = 8'h88;
  localparam logic [7:0] FLOPPY_MISC_POR = 8'h70;
  localparam logic [7:0] FLOPPY_MISC_MASK = 8'h72;
  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  localparam logic [15:0] BASE_ADDR_MIN = 16'h0100;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PERS_THIRD,
    PERS_SECOND,
    PERS_RESERVED,
    PERS_AT
  } personality_t;
  typedef struct packed {
    logic primary_enable;
    logic secondary_enable;
    logic infrared_enable;
  } serial_power_t;
  typedef struct packed {
    logic enhanced_mode2;
    logic density_force_high;
    personality_t personality;
  } floppy_ctrl_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } cfg_access_t;
endpackage
`default_nettype wire

// [verification/cfg_host_model.sv]
// host software model: loads the config index and makes one-cycle register accesses
`default_nettype none
module cfg_host_model (
  // clock
  input wire logic clk,
  // access toward the device
  output var cfg_regs_pkg::cfg_access_t acc,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid,
  input wire logic next_reg_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // access tasks, driven on the falling edge
  // ---------------------------------------------------------------
  initial acc = '0;
  // index is loaded together with the strobe, and held after it drops
  task automatic cfg_write(input logic [7:0] idx, input logic [7:0] wd);
    @(negedge clk);
    acc = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: wd};
    @(negedge clk);
    acc.wr = 1'b0;
  endtask
  // read data is a one-cycle pulse, so it is taken at the next falling edge
  task automatic cfg_read(input logic [7:0] idx, output logic [7:0] d, output logic v, output logic sel);
    @(negedge clk);
    acc = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 8'h00};
    #1;
    sel = next_reg_sel;
    @(negedge clk);
    d = rdata;
    v = rdata_valid;
    acc.rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the serial power and floppy misc config registers
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, hard_reset, config_state, density_programmed;
  logic [15:0] host_addr, primary_base, secondary_base;
  logic [7:0] rdata, d, w, sp, fm;
  logic rdata_valid, next_reg_sel, configuration_lock_bit, v, sel;
  logic primary_addr_hit, secondary_addr_hit, drive_density_select_out;
  cfg_regs_pkg::cfg_access_t acc;
  cfg_regs_pkg::serial_power_t serial_power;
  cfg_regs_pkg::floppy_ctrl_t floppy_ctrl;
  int miscompares, tests_run;
  // ---------------------------------------------------------------
  // design and host model
  // ---------------------------------------------------------------
  serial_floppy_config_regs u_dut (.clk(clk), .rst_n(rst_n), .hard_reset(hard_reset),
    .config_state(config_state), .acc(acc), .rdata(rdata), .rdata_valid(rdata_valid),
    .next_reg_sel(next_reg_sel), .configuration_lock_bit(configuration_lock_bit),
    .host_addr(host_addr), .primary_base(primary_base), .secondary_base(secondary_base),
    .primary_addr_hit(primary_addr_hit), .secondary_addr_hit(secondary_addr_hit),
    .serial_power(serial_power), .floppy_ctrl(floppy_ctrl),
    .density_programmed(density_programmed), .drive_density_select_out(drive_density_select_out));
  cfg_host_model u_host (.clk(clk), .acc(acc), .rdata(rdata), .rdata_valid(rdata_valid),
    .next_reg_sel(next_reg_sel));
  // ---------------------------------------------------------------
  // expectations and checks
  // ---------------------------------------------------------------
  function automatic logic hit_exp(input logic [15:0] a, input logic [15:0] b);
    return (b >= 16'h0100) && (a >= b) && ({1'b0, a} < {1'b0, b} + 17'h00008);
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    u_host.cfg_read(idx, d, v, sel);
    check("rdata_valid", 16'(v), 16'h0001);
    check("rdata", 16'(d), 16'(exp));
    check("next_reg_sel", 16'(sel), 16'(idx == 8'h04));
  endtask
  task automatic out_chk();
    check("serial_power", 16'(serial_power), 16'({sp[3], sp[7], sp[7]}));
    check("floppy_ctrl", 16'(floppy_ctrl), 16'({fm[1], fm[4], fm[6], fm[5]}));
    check("drive_density", 16'(drive_density_select_out), 16'(fm[4] | density_programmed));
  endtask
  // pin is synchronised, so allow a few edges before looking at its effect
  task automatic pulse_hard();
    @(negedge clk);
    hard_reset = 1'b1;
    @(negedge clk);
    hard_reset = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // the whole run needs under two thousand cycles
  initial begin
    #2000000;
    miscompares++;
    finish_test();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    hard_reset = 1'b0;
    config_state = 1'b1;
    density_programmed = 1'b0;
    host_addr = 16'h0000;
    primary_base = 16'h0000;
    secondary_base = 16'h0000;
    miscompares = 0;
    tests_run = 0;
    sp = 8'h08;
    fm = 8'h70;
    void'($urandom(6886));
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(8'h02, 8'h08);
    rd_chk(8'h03, 8'h70);
    rd_chk(8'h01, 8'h80);
    out_chk();
    // random contents, the first four walk every personality code
    for (int i = 0; i < 24; i++) begin
      w = 8'($urandom());
      u_host.cfg_write(8'h02, w);
      sp = w & 8'h88;
      w = 8'($urandom());
      if (i < 4) w[6:5] = i[1:0];
      density_programmed = 1'($urandom());
      u_host.cfg_write(8'h03, w);
      fm = w & 8'h72;
      rd_chk(8'h02, sp);
      rd_chk(8'h03, fm);
      out_chk();
    end
    u_host.cfg_read(8'h04, d, v, sel);
    check("next_reg_sel", 16'(sel), 16'h0001);
    rd_chk(8'h20, 8'h00);
    // refused outside the configuration state
    config_state = 1'b0;
    u_host.cfg_write(8'h02, ~sp);
    u_host.cfg_read(8'h02, d, v, sel);
    check("rdata_valid", 16'(v), 16'h0000);
    config_state = 1'b1;
    rd_chk(8'h02, sp);
    // hard reset clears only the secondary power bit
    u_host.cfg_write(8'h02, 8'h88);
    pulse_hard();
    rd_chk(8'h02, 8'h08);
    rd_chk(8'h03, fm);
    sp = 8'h08;
    // decode with both ports powered down
    u_host.cfg_write(8'h02, 8'h00);
    sp = 8'h00;
    out_chk();
    for (int i = 0; i < 40; i++) begin
      primary_base = (i % 4 == 0) ? 16'($urandom_range(255)) : 16'($urandom_range(16'hff00, 16'h0100));
      host_addr = primary_base + 16'($urandom_range(9)) - 16'h0001;
      secondary_base = host_addr - 16'($urandom_range(9));
      #1;
      check("primary_addr_hit", 16'(primary_addr_hit), 16'(hit_exp(host_addr, primary_base)));
      check("secondary_addr_hit", 16'(secondary_addr_hit), 16'(hit_exp(host_addr, secondary_base)));
      @(negedge clk);
    end
    // locking blocks access until a hard reset
    u_host.cfg_write(8'h01, 8'h00);
    check("configuration_lock_bit", 16'(configuration_lock_bit), 16'h0000);
    u_host.cfg_write(8'h03, 8'h00);
    u_host.cfg_read(8'h03, d, v, sel);
    check("rdata_valid", 16'(v), 16'h0000);
    pulse_hard();
    check("configuration_lock_bit", 16'(configuration_lock_bit), 16'h0001);
    rd_chk(8'h03, fm);
    rd_chk(8'h01, 8'h80);
    finish_test();
  end
endmodule
`default_nettype wire
